// ---- switch_global_control_regs.sv ----
//
// Function
// - Tag mask enabled: low five VID bits select egress ports.
// - Tag mask only acts while VLAN enable is clear.
// - Sniff select set needs source and destination match; clear needs either.
// - Back pressure bit applies half-duplex back pressure on switch port.
// - Duplex bit set is half duplex; reset from duplex strap.
// - Flow control bit enables full-duplex flow control; reset from strap.
// - Speed bit set is 10Mbps, clear 100Mbps; reset from strap.
// - Null VID replacement swaps null VID for port default VID.
// - Storm limit is eleven bits split across registers 0x06 and 0x07.
// - Storm window is 50ms at 100Mbps, 500ms at 10Mbps.
// - Storm limit resets to 0x4a low, zero high.
// - VLAN enable bit turns VLAN forwarding on; table set first.
//
`timescale 1ns/1ps
`include "glob_ctrl_consts.svh"

module switch_global_control_regs
	import glob_ctrl_pkg::*;
#(
	parameter int NUM_PORTS = 5,
	parameter int WIN_100_CYC = `STORM_WIN_100_MS * `CLK_KHZ,
	parameter int WIN_10_CYC = `STORM_WIN_10_MS * `CLK_KHZ
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Management register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Strap pins
	input wire logic duplex_strap_pin,
	input wire logic flow_strap_pin,
	input wire logic speed_strap_pin,
	// Forwarding lookup
	input wire logic fwd_req_valid,
	input wire fwd_req_type fwd_req,
	output logic fwd_ans_valid,
	output fwd_ans_type fwd_ans,
	// Broadcast storm
	input wire logic [NUM_PORTS-1:0] bcast_block,
	output logic [NUM_PORTS-1:0] storm_drop,
	// Switch port settings
	output mac_ctrl_type mac_ctrl
);

	// ----------------------------------------
	// Strap synchronisers
	// ----------------------------------------
	logic [2:0] strap_s1_reg, strap_s2_reg, strap_s3_reg;
	logic [2:0] settle_reg, settle_next;
	logic strap_load;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_s1_reg <= 3'h0;
			strap_s2_reg <= 3'h0;
			strap_s3_reg <= 3'h0;
		end else begin
			strap_s1_reg <= {duplex_strap_pin, flow_strap_pin, speed_strap_pin};
			strap_s2_reg <= strap_s1_reg;
			strap_s3_reg <= strap_s2_reg;
		end
	end

	// Straps caught once the chain has filled after release
	always_comb begin
		settle_next = settle_reg;
		if (settle_reg != `STRAP_SETTLE_CYC) begin
			settle_next = settle_reg + 3'd1;
		end
	end
	assign strap_load = (settle_reg == `STRAP_SETTLE_CYC - 3'd1);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			settle_reg <= 3'h0;
		end else begin
			settle_reg <= settle_next;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] fwd_opt_reg, fwd_opt_next;
	logic [7:0] port_link_reg, port_link_next;
	logic [7:0] storm_low_reg, storm_low_next;
	logic [7:0] rdata_next;
	logic [10:0] storm_limit;

	always_comb begin
		fwd_opt_next = fwd_opt_reg;
		port_link_next = port_link_reg;
		storm_low_next = storm_low_reg;
		if (reg_wr) begin
			case (reg_addr)
				`OFS_FWD_OPT: begin
					fwd_opt_next = reg_wdata & `FWD_OPT_WR_MASK;
				end
				`OFS_PORT_LINK: begin
					port_link_next = reg_wdata;
				end
				`OFS_STORM_LOW: begin
					storm_low_next = reg_wdata;
				end
				default: begin
				end
			endcase
		end
		if (strap_load && (strap_s2_reg == strap_s3_reg)) begin
			port_link_next[`PL_HALF_DUP] = strap_s3_reg[2];
			port_link_next[`PL_FLOW_EN] = strap_s3_reg[1];
			port_link_next[`PL_SPEED_10] = strap_s3_reg[0];
		end
	end

	always_comb begin
		case (reg_addr)
			`OFS_FWD_OPT: rdata_next = fwd_opt_reg;
			`OFS_PORT_LINK: rdata_next = port_link_reg;
			`OFS_STORM_LOW: rdata_next = storm_low_reg;
			`OFS_FACT_A: rdata_next = `RST_FACT_A;
			`OFS_FACT_B: rdata_next = `RST_FACT_B;
			default: rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fwd_opt_reg <= `RST_FWD_OPT;
			port_link_reg <= `RST_PORT_LINK;
			storm_low_reg <= `RST_STORM_LOW;
			reg_rdata <= 8'h00;
			mac_ctrl <= '0;
		end else begin
			fwd_opt_reg <= fwd_opt_next;
			port_link_reg <= port_link_next;
			storm_low_reg <= storm_low_next;
			reg_rdata <= rdata_next;
			mac_ctrl.pretag_en <= fwd_opt_reg[`FO_PRETAG];
			mac_ctrl.backpressure_en <= port_link_reg[`PL_BACKPRES];
			mac_ctrl.half_duplex <= port_link_reg[`PL_HALF_DUP];
			mac_ctrl.flow_ctrl_en <= port_link_reg[`PL_FLOW_EN];
			mac_ctrl.speed_10 <= port_link_reg[`PL_SPEED_10];
			mac_ctrl.vlan_en <= fwd_opt_reg[`FO_VLAN_EN];
		end
	end

	assign storm_limit = {port_link_reg[`PL_STORM_HI_MSB:0], storm_low_reg};

	// ----------------------------------------
	// Forwarding lookup
	// ----------------------------------------
	fwd_ans_type ans_next;

	always_comb begin
		ans_next.vid = fwd_req.vid;
		if (port_link_reg[`PL_NULL_VID] && (fwd_req.vid == 12'h000)) begin
			ans_next.vid = fwd_req.port_vid;
		end
		ans_next.mask_valid = fwd_opt_reg[`FO_TAG_MASK] && !fwd_opt_reg[`FO_VLAN_EN];
		ans_next.port_mask = ans_next.mask_valid ? fwd_req.vid[4:0] : 5'h00;
		if (fwd_opt_reg[`FO_SNIFF_AND]) begin
			ans_next.sniff = fwd_req.src_match && fwd_req.dst_match;
		end else begin
			ans_next.sniff = fwd_req.src_match || fwd_req.dst_match;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fwd_ans_valid <= 1'b0;
			fwd_ans <= '0;
		end else begin
			fwd_ans_valid <= fwd_req_valid;
			fwd_ans <= ans_next;
		end
	end

	// ----------------------------------------
	// Broadcast storm window
	// ----------------------------------------
	logic [31:0] win_cnt_reg, win_cnt_next;
	logic win_end;

	always_comb begin
		win_end = port_link_reg[`PL_SPEED_10] ? (win_cnt_reg >= 32'(WIN_10_CYC - 1))
			: (win_cnt_reg >= 32'(WIN_100_CYC - 1));
		win_cnt_next = win_end ? 32'h0 : win_cnt_reg + 32'h1;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			win_cnt_reg <= 32'h0;
		end else begin
			win_cnt_reg <= win_cnt_next;
		end
	end

	// Blocks on the window's last cycle count into the new window
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			logic [10:0] blk_cnt_reg, blk_cnt_next;
			logic drop_next;

			always_comb begin
				blk_cnt_next = win_end ? 11'h000 : blk_cnt_reg;
				drop_next = 1'b0;
				if (bcast_block[p]) begin
					if (blk_cnt_next < storm_limit) begin
						blk_cnt_next = blk_cnt_next + 11'h001;
					end else begin
						drop_next = 1'b1;
					end
				end
			end

			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					blk_cnt_reg <= 11'h000;
					storm_drop[p] <= 1'b0;
				end else begin
					blk_cnt_reg <= blk_cnt_next;
					storm_drop[p] <= drop_next;
				end
			end
		end
	endgenerate

endmodule : switch_global_control_regs

// ---- glob_ctrl_consts.svh ----
`ifndef GLOB_CTRL_CONSTS_SVH
`define GLOB_CTRL_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_FWD_OPT 8'h05
`define OFS_PORT_LINK 8'h06
`define OFS_STORM_LOW 8'h07
`define OFS_FACT_A 8'h08
`define OFS_FACT_B 8'h09

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define RST_FWD_OPT 8'h00
`define RST_PORT_LINK 8'h00
`define RST_STORM_LOW 8'h4a
`define RST_FACT_A 8'h00
`define RST_FACT_B 8'h4c
`define FWD_OPT_WR_MASK 8'hf3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FO_VLAN_EN 7
`define FO_PRETAG 4
`define FO_TAG_MASK 1
`define FO_SNIFF_AND 0
`define PL_BACKPRES 7
`define PL_HALF_DUP 6
`define PL_FLOW_EN 5
`define PL_SPEED_10 4
`define PL_NULL_VID 3
`define PL_STORM_HI_MSB 2

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_KHZ 125000
`define STORM_WIN_100_MS 50
`define STORM_WIN_10_MS 500
`define STRAP_SETTLE_CYC 3'd4

`endif

// ---- glob_ctrl_pkg.sv ----
package glob_ctrl_pkg;

	typedef struct packed {
		logic [11:0] vid;
		logic [11:0] port_vid;
		logic src_match;
		logic dst_match;
	} fwd_req_type;

	typedef struct packed {
		logic [11:0] vid;
		logic [4:0] port_mask;
		logic mask_valid;
		logic sniff;
	} fwd_ans_type;

	typedef struct packed {
		logic pretag_en;
		logic backpressure_en;
		logic half_duplex;
		logic flow_ctrl_en;
		logic speed_10;
		logic vlan_en;
	} mac_ctrl_type;

endpackage : glob_ctrl_pkg

// ---- strap_pull_model.sv ----
`timescale 1ns/1ps
module strap_pull_model (
	// Board strap fit
	input wire logic [2:0] pull_up,
	// Strap pins
	output logic duplex_strap_pin,
	output logic flow_strap_pin,
	output logic speed_strap_pin
);
	assign {duplex_strap_pin, flow_strap_pin, speed_strap_pin} = pull_up;
endmodule : strap_pull_model

// ---- glob_ctrl_props.sv ----
`timescale 1ns/1ps
module glob_ctrl_props
	import glob_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Watched ports
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic fwd_req_valid,
	input wire fwd_req_type fwd_req,
	input wire logic fwd_ans_valid,
	input wire fwd_ans_type fwd_ans,
	input wire mac_ctrl_type mac_ctrl
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_ans_lat; fwd_req_valid |=> fwd_ans_valid; endproperty
	a_ans_lat: assert property (p_ans_lat) else $error("lookup answer late");
	property p_mask;
		fwd_ans_valid && fwd_ans.mask_valid |-> fwd_ans.port_mask == $past(fwd_req.vid[4:0]);
	endproperty
	a_mask: assert property (p_mask) else $error("port mask wrong");
	property p_vlan; fwd_ans_valid && mac_ctrl.vlan_en |-> !fwd_ans.mask_valid; endproperty
	a_vlan: assert property (p_vlan) else $error("mask used in vlan mode");
	property p_sn_and;
		fwd_req_valid && fwd_req.src_match && fwd_req.dst_match |=> fwd_ans.sniff;
	endproperty
	a_sn_and: assert property (p_sn_and) else $error("sniff missed");
	property p_sn_none;
		fwd_req_valid && !fwd_req.src_match && !fwd_req.dst_match |=> !fwd_ans.sniff;
	endproperty
	a_sn_none: assert property (p_sn_none) else $error("sniff without match");
	property p_vid; fwd_req_valid && fwd_req.vid != 0 |=> fwd_ans.vid == $past(fwd_req.vid); endproperty
	a_vid: assert property (p_vid) else $error("vid altered");
	property p_fa; reg_addr == 8'h08 |=> reg_rdata == 8'h00; endproperty
	a_fa: assert property (p_fa) else $error("test reg a changed");
	property p_fb; reg_addr == 8'h09 |=> reg_rdata == 8'h4c; endproperty
	a_fb: assert property (p_fb) else $error("test reg b changed");
	property p_bp;
		reg_wr && reg_addr == 8'h06 |=> ##1 mac_ctrl.backpressure_en == $past(reg_wdata[7], 2);
	endproperty
	a_bp: assert property (p_bp) else $error("back pressure not set");
endmodule : glob_ctrl_props
bind switch_global_control_regs glob_ctrl_props i_glob_ctrl_props (.sys_clk, .rst_b, .reg_addr,
	.reg_wr, .reg_wdata, .reg_rdata, .fwd_req_valid, .fwd_req, .fwd_ans_valid, .fwd_ans, .mac_ctrl);

// ---- switch_global_control_regs_tb_top.sv ----
`timescale 1ns/1ps
module switch_global_control_regs_tb_top
	import glob_ctrl_pkg::*;
;
	logic sys_clk, rst_b, reg_wr, fwd_req_valid, fwd_ans_valid;
	logic duplex_strap_pin, flow_strap_pin, speed_strap_pin;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [4:0] bcast_block, storm_drop;
	logic [2:0] pull_up;
	fwd_req_type fwd_req;
	fwd_ans_type fwd_ans, ans;
	mac_ctrl_type mac_ctrl;
	int err_count, compares;
	switch_global_control_regs #(.WIN_100_CYC(50), .WIN_10_CYC(500)) i_switch_global_control_regs (
		.sys_clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .duplex_strap_pin,
		.flow_strap_pin, .speed_strap_pin, .fwd_req_valid, .fwd_req, .fwd_ans_valid, .fwd_ans,
		.bcast_block, .storm_drop, .mac_ctrl);
	strap_pull_model i_strap_pull_model (.pull_up, .duplex_strap_pin, .flow_strap_pin,
		.speed_strap_pin);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Idle edge first so the strobe never rises in the step it fell
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) #1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge sys_clk) #1;
		reg_wr = 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		@(posedge sys_clk) #1;
		chk(reg_rdata, exp);
	endtask : rd
	task fwd(input logic [11:0] v, input logic [11:0] pv, input logic s, input logic d);
		@(posedge sys_clk) #1;
		fwd_req = {v, pv, s, d};
		fwd_req_valid = 1'b1;
		@(posedge sys_clk) #1;
		fwd_req_valid = 1'b0;
		chk(fwd_ans_valid, 1);
		ans = fwd_ans;
	endtask : fwd
	task end_sim;
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		rd(8'h05, 8'h00);
		rd(8'h06, 8'h00);
		rd(8'h07, 8'h4a);
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h4c);
		rd(8'h0a, 8'h00);
		$display("reset test done");
	endtask : t_reset
	task t_strap;
		pull_up = 3'h7;
		rst_b = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1 rst_b = 1'b1;
		repeat (6) @(posedge sys_clk);
		#1 rd(8'h06, 8'h70);
		pull_up = 3'h0;
		$display("strap test done");
	endtask : t_strap
	task t_regs;
		wr(8'h08, 8'hff);
		wr(8'h09, 8'hff);
		wr(8'h05, 8'hff);
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h4c);
		rd(8'h05, 8'hf3);
		wr(8'h06, 8'h80);
		@(posedge sys_clk) #1;
		chk(mac_ctrl, 6'h31);
		wr(8'h06, 8'h70);
		@(posedge sys_clk) #1;
		chk(mac_ctrl, 6'h2f);
		$display("register test done");
	endtask : t_regs
	task t_fwd;
		wr(8'h05, 8'h82);
		fwd(12'h015, 12'h0, 1, 0);
		chk(ans.mask_valid, 0);
		chk(ans.sniff, 1);
		wr(8'h05, 8'h03);
		fwd(12'h015, 12'h0, 1, 0);
		chk({ans.mask_valid, ans.port_mask}, 6'h35);
		chk(ans.sniff, 0);
		fwd(12'h0, 12'h123, 1, 1);
		chk(ans.sniff, 1);
		chk(ans.vid, 12'h000);
		wr(8'h06, 8'h08);
		fwd(12'h0, 12'h123, 0, 0);
		chk(ans.sniff, 0);
		chk(ans.vid, 12'h123);
		$display("lookup test done");
	endtask : t_fwd
	// Any span of whole windows lets exactly limit blocks per window through
	task t_storm(input logic [7:0] r6, input logic [7:0] r7, input int n, input int exp);
		int pass;
		logic [3:0] other;
		pass = 0;
		other = 4'h0;
		wr(8'h06, r6);
		wr(8'h07, r7);
		bcast_block = 5'h01;
		repeat (600) @(posedge sys_clk);
		repeat (n) begin
			@(posedge sys_clk) #1;
			pass += !storm_drop[0];
			other |= storm_drop[4:1];
		end
		bcast_block = 5'h00;
		chk(12'(pass), 12'(exp));
		chk(other, 0);
		$display("storm test done");
	endtask : t_storm
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		#100000;
		err_count++;
		end_sim();
	end
	initial begin
		{rst_b, reg_wr, fwd_req_valid, reg_addr, reg_wdata, bcast_block, pull_up} = '0;
		fwd_req = '0;
		repeat (3) @(posedge sys_clk);
		#1 rst_b = 1'b1;
		repeat (6) @(posedge sys_clk);
		#1 t_reset();
		t_strap();
		t_regs();
		t_fwd();
		t_storm(8'h00, 8'h02, 100, 4);
		t_storm(8'h11, 8'h00, 1000, 512);
		end_sim();
	end
endmodule : switch_global_control_regs_tb_top
